// [logic/hbp_pkg.sv]
// constants, field layouts and helpers of the half-bridge pwm control
package hbp_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 100;
  localparam int BD_PERIOD_NS      = 1000;
  localparam int BD_DIV_CYC        = (BD_PERIOD_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
  localparam int SYNC_STAGES       = 2;
  localparam int INPUT_SYNC_DELAY  = SYNC_STAGES;
  localparam int CNT_W             = 4;
  localparam logic [3:0] CHG_TICKS  = 4'h4;
  localparam logic [3:0] DCHG_TICKS = 4'h4;
  localparam logic [3:0] FW_TICKS   = 4'h4;

  // ---------------------------------------------------------------
  // current codes
  // ---------------------------------------------------------------
  localparam int CODE_W              = 6;
  localparam logic [5:0] CODE_MIN     = 6'h00;
  localparam logic [5:0] HARD_OFF_CODE = 6'h3f;
  localparam logic [5:0] HOLD_CODE_LO = 6'h0f;
  localparam logic [5:0] HOLD_CODE_HI = 6'h14;

  // ---------------------------------------------------------------
  // register map (word index = byte address / 4)
  // ---------------------------------------------------------------
  localparam int ADDR_W          = 8;
  localparam int NUM_BRIDGES     = 3;
  localparam int GENERAL_CONTROL = 0;
  localparam int HB_MODE_CTRL    = 1;
  localparam int MAX_CURRENT_CFG = 2;
  localparam int CHARGE_CUR_CFG  = 3;
  localparam int DISCHG_CUR_CFG  = 4;
  localparam int FW_CUR_CFG      = 5;
  localparam int PRECHARGE_TIME  = 6;
  localparam int PCHG_INIT_CFG   = 7;
  localparam int PDCHG_INIT_CFG  = 8;
  localparam int CFG_N           = 9;
  localparam int GATE_STATUS     = 9;
  localparam int PCHG_ADAPT_STAT = 10;
  localparam int PDCHG_ADAPT_STAT = 11;

  localparam logic [31:0] CFG_MASK [CFG_N] = '{
    32'h0000_001f, 32'h0000_0fff, 32'h003f_3f3f, 32'h003f_3f3f,
    32'h003f_3f3f, 32'h003f_3f3f, 32'h00ff_ffff, 32'h003f_3f3f,
    32'h003f_3f3f};
  localparam logic [31:0] CFG_RST [CFG_N] = '{
    32'h0000_0000, 32'h0000_0000, 32'h003f_3f3f, 32'h0020_2020,
    32'h0020_2020, 32'h0010_1010, 32'h0022_2222, 32'h0010_1010,
    32'h0010_1010};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int GC_POCD_BIT   = 0;
  localparam int GC_HOLD_BIT   = 1;
  localparam int GC_AGC_LSB    = 2;
  localparam int GC_PWMNB_BIT  = 4;
  localparam int HBM_STRIDE    = 4;
  localparam int HBM_MODE_LSB  = 0;
  localparam int HBM_EN_BIT    = 2;
  localparam int HBM_AFW_BIT   = 3;
  localparam int BYTE_STRIDE   = 8;
  localparam int PDCHG_T_LSB   = 4;
  localparam int ST_PWM_LSB    = 8;

  typedef enum logic [1:0] {
    HBM_PASSIVE_OFF, HBM_LS_PWM, HBM_HS_PWM, HBM_ACTIVE_OFF
  } hbp_mode_t;

  // limit a code to the configured maximum
  function automatic logic [5:0] hbp_clamp(input logic [5:0] v,
                                           input logic [5:0] mx);
    hbp_clamp = (v > mx) ? mx : v;
  endfunction

endpackage

// [logic/hbp_cfg_if.sv]
// configuration bundle handed from the register bank to one bridge leg
interface hbp_cfg_if;
  import hbp_pkg::*;
  hbp_mode_t   mode;
  logic        pwm_en;
  logic        active_freewheel_enable;
  logic        pwm_input_count_select;
  logic [1:0]  adaptive_gate_control_sel;
  logic        pocd;
  logic        hold_sel;
  logic [5:0]  max_cur;
  logic [5:0]  chg_cur;
  logic [5:0]  dchg_cur;
  logic [5:0]  fw_cur;
  logic [3:0]  tpchg;
  logic [3:0]  tpdchg;
  logic [5:0]  pinit;
  logic [5:0]  pdinit;
  modport ctrl (output mode, pwm_en, active_freewheel_enable, pwm_input_count_select, adaptive_gate_control_sel, pocd, hold_sel,
                max_cur, chg_cur, dchg_cur, fw_cur, tpchg, tpdchg,
                pinit, pdinit);
  modport leg  (input mode, pwm_en, active_freewheel_enable, pwm_input_count_select, adaptive_gate_control_sel, pocd, hold_sel,
                max_cur, chg_cur, dchg_cur, fw_cur, tpchg, tpdchg,
                pinit, pdinit);
endinterface

// [logic/hbp_sync.sv]
// two-stage synchroniser for asynchronous inputs
module hbp_sync
  import hbp_pkg::*;
#(
  parameter int W = 1
)(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;
endmodule

// [logic/hbp_leg.sv]
// gate sequencer of one half-bridge: pwm switch phases and free-wheeling
module hbp_leg
  import hbp_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic bd_tick,
  // control
  input  wire logic pwm,
  input  wire logic ton_slow,
  input  wire logic toff_slow,
  hbp_cfg_if.leg    cfg,
  // gate drive
  output logic       hs_on,
  output logic       hs_src,
  output logic [5:0] hs_code,
  output logic       ls_on,
  output logic       ls_src,
  output logic [5:0] ls_code,
  output logic [5:0] pchg_code,
  output logic [5:0] pdchg_code
);
  typedef enum logic [2:0] {
    S_OFF, S_PRE_ON, S_CHG, S_POST, S_ON, S_PRE_OFF, S_DCHG
  } hbp_leg_state_t;

  hbp_leg_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next, fw_cnt_reg, fw_cnt_next;
  logic [5:0] ramp_reg, ramp_next, pc_reg, pc_next, pd_reg, pd_next;
  logic       fw_on_reg, fw_on_next;
  logic       pwm_ctrl, static_on, cmd_on, afw_act, want_fw, forced;
  logic       pre_on_skip, pre_off_skip, last, is_on_side, main_hs;
  logic       m_on, m_src, o_on, o_src;
  logic [5:0] hold, m_code, o_code;

  always_comb
  begin
    pwm_ctrl  = cfg.pwm_en && !cfg.pwm_input_count_select
                && (cfg.mode == HBM_LS_PWM || cfg.mode == HBM_HS_PWM);
    // six-input pwm is not served: an enabled bridge there stays off
    static_on = (cfg.mode == HBM_LS_PWM || cfg.mode == HBM_HS_PWM)
                && !cfg.pwm_en;
    cmd_on    = pwm_ctrl ? pwm : static_on;
    afw_act   = cfg.active_freewheel_enable && cfg.pwm_en && !cfg.pwm_input_count_select;
    forced    = cfg.mode == HBM_PASSIVE_OFF || cfg.mode == HBM_ACTIVE_OFF;
    main_hs   = cfg.mode == HBM_HS_PWM;
    pre_on_skip  = cfg.adaptive_gate_control_sel == 2'b00 || cfg.tpchg == '0;
    pre_off_skip = cfg.adaptive_gate_control_sel == 2'b00 || cfg.tpdchg == '0;
    last      = bd_tick && cnt_reg <= 4'h1;
    is_on_side = state_reg == S_PRE_ON || state_reg == S_CHG
                 || state_reg == S_POST || state_reg == S_ON;
    hold      = cfg.hold_sel ? HOLD_CODE_HI : HOLD_CODE_LO;
    state_next = state_reg;
    cnt_next   = (bd_tick && cnt_reg != '0) ? cnt_reg - 4'h1 : cnt_reg;
    ramp_next  = ramp_reg;
    // adaptive codes follow the initial values unless adaptation is on
    pc_next = cfg.adaptive_gate_control_sel[1] ? hbp_clamp(pc_reg, cfg.max_cur)
                         : hbp_clamp(cfg.pinit, cfg.max_cur);
    pd_next = cfg.adaptive_gate_control_sel[1] ? hbp_clamp(pd_reg, cfg.max_cur)
                         : hbp_clamp(cfg.pdinit, cfg.max_cur);
    want_fw = afw_act && pwm_ctrl && !cmd_on && state_reg == S_OFF;
    fw_on_next  = fw_on_reg;
    fw_cnt_next = (bd_tick && fw_cnt_reg != '0) ? fw_cnt_reg - 4'h1
                                                : fw_cnt_reg;
    if (forced)
    begin
      state_next  = S_OFF;
      fw_on_next  = 1'b0;
      fw_cnt_next = '0;
    end
    else if (want_fw != fw_on_reg)
    begin
      fw_on_next  = want_fw;
      fw_cnt_next = FW_TICKS;
    end
    else if (is_on_side && !cmd_on)
    begin
      state_next = pre_off_skip ? S_DCHG : S_PRE_OFF;
      cnt_next   = pre_off_skip ? DCHG_TICKS : cfg.tpdchg;
    end
    else
    begin
      case (state_reg)
        S_OFF:
        if (cmd_on && !fw_on_reg && fw_cnt_reg == '0)
        begin
          state_next = pre_on_skip ? S_CHG : S_PRE_ON;
          cnt_next   = pre_on_skip ? CHG_TICKS : cfg.tpchg;
        end
        S_PRE_ON:
        if (last)
        begin
          state_next = S_CHG;
          cnt_next   = CHG_TICKS;
          if (cfg.adaptive_gate_control_sel[1] && ton_slow && pc_reg < cfg.max_cur)
            pc_next = pc_reg + 6'h01;
          else if (cfg.adaptive_gate_control_sel[1] && !ton_slow && pc_reg > CODE_MIN)
            pc_next = pc_reg - 6'h01;
        end
        S_CHG:
        begin
          ramp_next = cfg.chg_cur;
          if (last)
            state_next = cfg.pocd ? S_ON : S_POST;
        end
        S_POST:
        if (ramp_reg >= cfg.max_cur)
          state_next = S_ON;
        else if (bd_tick)
          ramp_next = ramp_reg + 6'h01;
        S_ON:
          ramp_next = cfg.pocd ? cfg.chg_cur : ramp_reg;
        S_PRE_OFF:
        if (last)
        begin
          state_next = S_DCHG;
          cnt_next   = DCHG_TICKS;
          if (cfg.adaptive_gate_control_sel[1] && toff_slow && pd_reg < cfg.max_cur)
            pd_next = pd_reg + 6'h01;
          else if (cfg.adaptive_gate_control_sel[1] && !toff_slow && pd_reg > CODE_MIN)
            pd_next = pd_reg - 6'h01;
        end
        S_DCHG:
        if (last)
          state_next = S_OFF;
        default:
          state_next = S_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg  <= S_OFF;
      cnt_reg    <= '0;
      ramp_reg   <= '0;
      pc_reg     <= '0;
      pd_reg     <= '0;
      fw_on_reg  <= 1'b0;
      fw_cnt_reg <= '0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      ramp_reg   <= ramp_next;
      pc_reg     <= pc_next;
      pd_reg     <= pd_next;
      fw_on_reg  <= fw_on_next;
      fw_cnt_reg <= fw_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // drive of the pwm switch and of the opposite switch
  // ---------------------------------------------------------------
  always_comb
  begin
    m_on   = is_on_side;
    m_src  = is_on_side;
    case (state_reg)
      S_PRE_ON:  m_code = pc_reg;
      S_CHG:     m_code = cfg.chg_cur;
      S_POST:    m_code = ramp_reg;
      S_ON:      m_code = ramp_reg;
      S_PRE_OFF: m_code = pd_reg;
      S_DCHG:    m_code = cfg.dchg_cur;
      default:   m_code = hold;
    endcase
    o_on  = fw_on_reg;
    o_src = fw_on_reg;
    if (fw_cnt_reg != '0)
      o_code = cfg.fw_cur;
    else if (!fw_on_reg && (state_reg == S_PRE_ON || state_reg == S_CHG))
      o_code = HARD_OFF_CODE;
    else
      o_code = hold;
    hs_on = main_hs ? m_on : o_on;
    hs_src = main_hs ? m_src : o_src;
    hs_code = main_hs ? m_code : o_code;
    ls_on = main_hs ? o_on : m_on;
    ls_src = main_hs ? o_src : m_src;
    ls_code = main_hs ? o_code : m_code;
    if (cfg.mode == HBM_PASSIVE_OFF)
    begin
      {hs_on, hs_src, ls_on, ls_src} = 4'h0;
      hs_code = CODE_MIN;
      ls_code = CODE_MIN;
    end
    else if (cfg.mode == HBM_ACTIVE_OFF)
    begin
      {hs_on, hs_src, ls_on, ls_src} = 4'h0;
      hs_code = hold;
      ls_code = hold;
    end
    pchg_code  = pc_reg;
    pdchg_code = pd_reg;
  end
endmodule

// [logic/hbp_top.sv]
// register bank, pwm input mapping and three half-bridge gate sequencers
//------------------------------------------------------------------------
//------------------------------------------------------------------------
//
// The address-and-strobe port and the register offsets were left to the implementer.
module hbp_top
  import hbp_pkg::*;
#(
  parameter int BD_DIV = BD_DIV_CYC
)(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  // pwm pins
  input  wire logic                pwm_in_a,
  input  wire logic                pwm_in_b,
  input  wire logic                pwm_in_c,
  input  wire logic                pwm_in_d,
  input  wire logic                pwm_in_e,
  input  wire logic                pwm_in_f,
  // switching-time comparators, one per bridge
  input  wire logic [2:0]          ton_slow,
  input  wire logic [2:0]          toff_slow,
  // gate drive, one entry per bridge
  output logic      [2:0]          hs_on,
  output logic      [2:0]          hs_src,
  output logic      [2:0][5:0]     hs_code,
  output logic      [2:0]          ls_on,
  output logic      [2:0]          ls_src,
  output logic      [2:0][5:0]     ls_code
);

  //----------------------------------------------------------------------
  // elaboration checks
  //----------------------------------------------------------------------
  if (BD_DIV < 1 || BD_DIV > 255)
  begin : g_bad_div
    $error("bridge clock divider out of range");
  end

  //----------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------
  localparam int SYNC_W = 12;

  logic [31:0]       cfg_reg   [CFG_N];
  logic [31:0]       cfg_next  [CFG_N];
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic [7:0]        bd_cnt_reg;
  logic [7:0]        bd_cnt_next;
  logic              bd_tick_reg;
  logic              bd_tick_next;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic [5:0]        pwm_s;
  logic [2:0]        ton_s;
  logic [2:0]        toff_s;
  logic [2:0]        pwm_sel;
  logic [2:0]        l_hs_on;
  logic [2:0]        l_hs_src;
  logic [2:0][5:0]   l_hs_code;
  logic [2:0]        l_ls_on;
  logic [2:0]        l_ls_src;
  logic [2:0][5:0]   l_ls_code;
  logic [2:0][5:0]   l_pc;
  logic [2:0][5:0]   l_pd;
  logic [2:0]        hs_on_reg;
  logic [2:0]        hs_src_reg;
  logic [2:0][5:0]   hs_code_reg;
  logic [2:0]        ls_on_reg;
  logic [2:0]        ls_src_reg;
  logic [2:0][5:0]   ls_code_reg;
  logic [31:0]       status_word;
  logic [31:0]       pc_word;
  logic [31:0]       pd_word;

  //----------------------------------------------------------------------
  // address decoding
  //----------------------------------------------------------------------
  // misaligned addresses hit nothing: writes are dropped, reads give zero
  function automatic logic word_hit(input logic [ADDR_W-1:0] a,
                                    input int idx);
    word_hit = a[1:0] == 2'b00
               && a[ADDR_W-1:2] == idx[ADDR_W-3:0];
  endfunction

  function automatic logic [5:0] byte_field(input logic [31:0] w,
                                            input int b);
    byte_field = w[b*BYTE_STRIDE +: CODE_W];
  endfunction

  //----------------------------------------------------------------------
  // input synchronisation
  //----------------------------------------------------------------------
  // the comparators sit in the analog domain, so they share the flops
  assign sync_in = {toff_slow, ton_slow, pwm_in_f, pwm_in_e, pwm_in_d,
                    pwm_in_c, pwm_in_b, pwm_in_a};

  hbp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       (sync_in),
    .q       (sync_out)
  );

  assign pwm_s  = sync_out[5:0];
  assign ton_s  = sync_out[8:6];
  assign toff_s = sync_out[11:9];

  //----------------------------------------------------------------------
  // register bank
  //----------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < CFG_N; i++)
    begin
      cfg_next[i] = cfg_reg[i];
      if (reg_wr && word_hit(reg_addr, i))
        cfg_next[i] = reg_wdata & CFG_MASK[i];
    end
  end

  always_comb
  begin
    status_word = '0;
    pc_word     = '0;
    pd_word     = '0;
    for (int b = 0; b < NUM_BRIDGES; b++)
    begin
      status_word[2*b]     = hs_on_reg[b];
      status_word[2*b + 1] = ls_on_reg[b];
      pc_word[b*BYTE_STRIDE +: CODE_W] = l_pc[b];
      pd_word[b*BYTE_STRIDE +: CODE_W] = l_pd[b];
    end
    status_word[ST_PWM_LSB +: 6] = pwm_s;
  end

  always_comb
  begin
    rdata_next = '0;
    if (reg_rd)
    begin
      for (int i = 0; i < CFG_N; i++)
        if (word_hit(reg_addr, i))
          rdata_next = cfg_reg[i];
      if (word_hit(reg_addr, GATE_STATUS))
        rdata_next = status_word;
      if (word_hit(reg_addr, PCHG_ADAPT_STAT))
        rdata_next = pc_word;
      if (word_hit(reg_addr, PDCHG_ADAPT_STAT))
        rdata_next = pd_word;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < CFG_N; i++)
        cfg_reg[i] <= CFG_RST[i];
      rdata_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < CFG_N; i++)
        cfg_reg[i] <= cfg_next[i];
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  //----------------------------------------------------------------------
  // bridge driver clock
  //----------------------------------------------------------------------
  // a tick rather than a derived clock keeps the design in one domain
  always_comb
  begin
    bd_tick_next = bd_cnt_reg == 8'(BD_DIV - 1);
    bd_cnt_next  = bd_tick_next ? 8'h00 : bd_cnt_reg + 8'h01;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bd_cnt_reg  <= '0;
      bd_tick_reg <= 1'b0;
    end
    else
    begin
      bd_cnt_reg  <= bd_cnt_next;
      bd_tick_reg <= bd_tick_next;
    end
  end

  //----------------------------------------------------------------------
  // bridges
  //----------------------------------------------------------------------
  for (genvar b = 0; b < NUM_BRIDGES; b++)
  begin : g_leg
    hbp_cfg_if cfg_if ();

    // bridge b follows input a, c or e; b, d and f drive no bridge and only appear in the gate status word
    assign pwm_sel[b] = pwm_s[2*b];

    assign cfg_if.mode     = hbp_mode_t'(cfg_reg[HB_MODE_CTRL]
                             [b*HBM_STRIDE + HBM_MODE_LSB +: 2]);
    assign cfg_if.pwm_en   = cfg_reg[HB_MODE_CTRL]
                             [b*HBM_STRIDE + HBM_EN_BIT];
    assign cfg_if.active_freewheel_enable      = cfg_reg[HB_MODE_CTRL]
                             [b*HBM_STRIDE + HBM_AFW_BIT];
    assign cfg_if.pwm_input_count_select   = cfg_reg[GENERAL_CONTROL][GC_PWMNB_BIT];
    assign cfg_if.adaptive_gate_control_sel      = cfg_reg[GENERAL_CONTROL][GC_AGC_LSB +: 2];
    assign cfg_if.pocd     = cfg_reg[GENERAL_CONTROL][GC_POCD_BIT];
    assign cfg_if.hold_sel = cfg_reg[GENERAL_CONTROL][GC_HOLD_BIT];
    assign cfg_if.max_cur  = byte_field(cfg_reg[MAX_CURRENT_CFG], b);
    assign cfg_if.chg_cur  = byte_field(cfg_reg[CHARGE_CUR_CFG], b);
    assign cfg_if.dchg_cur = byte_field(cfg_reg[DISCHG_CUR_CFG], b);
    assign cfg_if.fw_cur   = byte_field(cfg_reg[FW_CUR_CFG], b);
    assign cfg_if.tpchg    = cfg_reg[PRECHARGE_TIME][b*BYTE_STRIDE +: 4];
    assign cfg_if.tpdchg   = cfg_reg[PRECHARGE_TIME]
                             [b*BYTE_STRIDE + PDCHG_T_LSB +: 4];
    assign cfg_if.pinit    = byte_field(cfg_reg[PCHG_INIT_CFG], b);
    assign cfg_if.pdinit   = byte_field(cfg_reg[PDCHG_INIT_CFG], b);

    hbp_leg u_leg (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .bd_tick    (bd_tick_reg),
      .pwm        (pwm_sel[b]),
      .ton_slow   (ton_s[b]),
      .toff_slow  (toff_s[b]),
      .cfg        (cfg_if.leg),
      .hs_on      (l_hs_on[b]),
      .hs_src     (l_hs_src[b]),
      .hs_code    (l_hs_code[b]),
      .ls_on      (l_ls_on[b]),
      .ls_src     (l_ls_src[b]),
      .ls_code    (l_ls_code[b]),
      .pchg_code  (l_pc[b]),
      .pdchg_code (l_pd[b])
    );
  end

  //----------------------------------------------------------------------
  // output registers
  //----------------------------------------------------------------------
  // one flop stage keeps the analog drivers free of decode glitches
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hs_on_reg   <= '0;
      hs_src_reg  <= '0;
      hs_code_reg <= '0;
      ls_on_reg   <= '0;
      ls_src_reg  <= '0;
      ls_code_reg <= '0;
    end
    else
    begin
      hs_on_reg   <= l_hs_on;
      hs_src_reg  <= l_hs_src;
      hs_code_reg <= l_hs_code;
      ls_on_reg   <= l_ls_on;
      ls_src_reg  <= l_ls_src;
      ls_code_reg <= l_ls_code;
    end
  end

  assign hs_on   = hs_on_reg;
  assign hs_src  = hs_src_reg;
  assign hs_code = hs_code_reg;
  assign ls_on   = ls_on_reg;
  assign ls_src  = ls_src_reg;
  assign ls_code = ls_code_reg;

endmodule

// [dv/hbp_props.sv]
// assertion checker of the half-bridge pwm control ports
module hbp_props
  import hbp_pkg::*;
#(
  parameter int BD_DIV = BD_DIV_CYC
)(
  // clock and reset
  input wire logic            ref_clk,
  input wire logic            nrst,
  // register port
  input wire logic [7:0]      reg_addr,
  input wire logic [31:0]     reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [31:0]     reg_rdata,
  // bridge one
  input wire logic            pwm_in_a,
  input wire logic [2:0]      hs_on,
  input wire logic [2:0]      hs_src,
  input wire logic [2:0][5:0] hs_code,
  input wire logic [2:0]      ls_on,
  input wire logic [2:0][5:0] ls_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // settle limit covers discharge plus free-wheel phases
  localparam int LIM = 20 * BD_DIV;
  logic [3:0] m_reg;
  logic [4:0] g_reg;
  int         stab_reg;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      m_reg    <= 4'h0;
      g_reg    <= 5'h00;
      stab_reg <= 0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h04)
        m_reg <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 8'h00)
        g_reg <= reg_wdata[4:0];
      if (reg_wr && reg_addr[7:3] == 5'h00)
        stab_reg <= 0;
      else if (stab_reg < LIM)
        stab_reg <= stab_reg + 1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_settled;
    stab_reg >= LIM;
  endsequence
  sequence s_launch;
    $rose(hs_on[0]) && m_reg[2:0] == 3'b110 && !g_reg[4];
  endsequence
  AST_RD_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_PASSIVE: assert property (s_settled ##0 m_reg[1:0] == 2'b00 |->
    !hs_on[0] && !ls_on[0] && hs_code[0] == 6'h00 && ls_code[0] == 6'h00)
    else $error("passive mode drives a gate");
  AST_ACT_OFF: assert property (s_settled ##0 m_reg[1:0] == 2'b11 |->
    !hs_on[0] && !ls_on[0] && !hs_src[0])
    else $error("active off mode turns a switch on");
  AST_LS_ONLY: assert property (s_settled ##0
    (m_reg[3:0] == 4'b0101 && !g_reg[4]) |-> !hs_on[0])
    else $error("high side on in low side mode");
  AST_NO_BOTH: assert property (!(hs_on[0] && ls_on[0]))
    else $error("both switches on");
  AST_SYNC: assert property (s_launch |-> $past(pwm_in_a, 4))
    else $error("turn-on faster than synchroniser");
  AST_HARD_OFF: assert property (s_launch |->
    ls_code[0] == HARD_OFF_CODE && !ls_on[0])
    else $error("no hard-off sink at turn-on");
  AST_RAMP: assert property (hs_on[0] && $past(hs_on[0]) &&
    g_reg[3:2] == 2'b00 && hs_code[0] > $past(hs_code[0]) |->
    hs_code[0] == $past(hs_code[0]) + 6'h01)
    else $error("post-charge step not one code");
endmodule

bind hbp_top hbp_props #(.BD_DIV(BD_DIV)) u_hbp_props (.ref_clk(ref_clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_in_a(pwm_in_a),
  .hs_on(hs_on), .hs_src(hs_src), .hs_code(hs_code), .ls_on(ls_on),
  .ls_code(ls_code));

// [dv/hbp_mcu.sv]
// microcontroller model driving the six pwm pins
module hbp_mcu (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // wanted levels of pins a, c, e
  input  wire logic [2:0] lvl,
  // pins a..f
  output logic      [5:0] pwm
);
  timeunit 1ns;
  timeprecision 1ns;
  // unused pins toggle every cycle so a wrong mapping cannot hide
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      pwm <= 6'h00;
    else
      pwm <= {~pwm[5], lvl[2], ~pwm[3], lvl[1], ~pwm[1], lvl[0]};
endmodule

// [dv/test_hbp_top.sv]
// self-checking bench of the half-bridge pwm control
module test_hbp_top;
  timeunit 1ns;
  timeprecision 1ns;
  import hbp_pkg::*;
  localparam int BD = 2;
  logic            ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0]      reg_addr = 8'h00;
  logic [31:0]     reg_wdata = 32'h0, reg_rdata;
  logic [2:0]      lvl = 3'h0, slow = 3'h0, hs_on, hs_src, ls_on, ls_src;
  logic [5:0]      pwm;
  logic [2:0][5:0] hs_code, ls_code;
  int              mismatches = 0, num_checks = 0;
  logic [31:0]     rst_val [9] = '{32'h0, 32'h0, 32'h003f_3f3f,
    32'h0020_2020, 32'h0020_2020, 32'h0010_1010, 32'h0022_2222,
    32'h0010_1010, 32'h0010_1010};
  always #50 ref_clk = ~ref_clk;
  hbp_mcu u_hbp_mcu (.ref_clk(ref_clk), .nrst(nrst), .lvl(lvl), .pwm(pwm));
  hbp_top #(.BD_DIV(BD)) u_hbp_top (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_in_a(pwm[0]),
    .pwm_in_b(pwm[1]), .pwm_in_c(pwm[2]), .pwm_in_d(pwm[3]),
    .pwm_in_e(pwm[4]), .pwm_in_f(pwm[5]), .ton_slow(slow),
    .toff_slow(slow), .hs_on(hs_on), .hs_src(hs_src), .hs_code(hs_code),
    .ls_on(ls_on), .ls_src(ls_src), .ls_code(ls_code));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // long enough for a full ramp from charge code to maximum
  task automatic settle;
    repeat (50 * BD) @(posedge ref_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rst_val[i]) rdc(8'(4 * i), rst_val[i]);
    rdc(8'h40, 32'h0);
    wr(8'h04, 32'hffff_ffff);
    rdc(8'h04, 32'h0000_0fff);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0000_000e);
    lvl <= 3'b001;
    settle;
    chk(32'({hs_on, ls_on}), 32'h8);
    chk(32'(hs_code[0]), 32'h3f);
    chk(32'(ls_code[0]), 32'h0f);
    lvl <= 3'b000;
    settle;
    chk(32'({hs_on, ls_on}), 32'h1);
    wr(8'h00, 32'h3);
    lvl <= 3'b001;
    settle;
    chk(32'(hs_code[0]), 32'h20);
    chk(32'(ls_code[0]), 32'h14);
    wr(8'h00, 32'h10);
    settle;
    chk(32'({hs_on, ls_on}), 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h5);
    settle;
    chk(32'({hs_on, ls_on}), 32'h1);
    lvl <= 3'b000;
    settle;
    chk(32'({hs_on, ls_on}), 32'h0);
    wr(8'h04, 32'h3);
    settle;
    chk(32'({hs_on, ls_on, ls_src}), 32'h0);
    wr(8'h04, 32'h0);
    settle;
    chk(32'({hs_code[0], ls_code[0]}), 32'h0);
    wr(8'h04, 32'h0000_0666);
    lvl <= 3'b010;
    settle;
    chk(32'(hs_on), 32'h2);
    wr(8'h08, 32'h003f_3f08);
    wr(8'h00, 32'h0000_0004);
    rdc(8'h28, 32'h0010_1008);
    rdc(8'h2c, 32'h0010_1008);
    wr(8'h00, 32'h0000_0008);
    wr(8'h08, 32'h003f_3f04);
    rdc(8'h28, 32'h0010_1004);
    rdc(8'h2c, 32'h0010_1004);
    tally_and_finish;
  end
endmodule
